// ===== core/sec_core.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sec_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic [2:0] stage;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage <= 3'h0;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      stage <= {stage[1:0], pin};
      rise <= 1'b0;
      // Only a value seen by two later stages counts as a change
      if (stage[1] == stage[2]) begin
        level <= stage[2];
        rise <= stage[2] & ~level;
      end
    end
  end
endmodule

module sec_field_counter #(
  parameter int W = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic field_step,
  input wire logic [2:0] action,
  input wire logic [W-1:0] limit,
  input wire logic [12:0] delay,
  input wire logic skip,
  output logic active,
  output logic started,
  output logic [W-1:0] count
);
  sec_pkg::sec_cnt_state_e state;
  logic [12:0] waited;
  assign active = (state == sec_pkg::SEC_RUN);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= sec_pkg::SEC_IDLE;
      count <= '0;
      waited <= 13'h0000;
      started <= 1'b0;
    end else begin
      started <= 1'b0;
      if (action == sec_pkg::ACT_FORCE_IDLE) begin
        state <= sec_pkg::SEC_IDLE;
        count <= '0;
        waited <= 13'h0000;
      end else if (field_step) begin
        unique case (state)
          sec_pkg::SEC_IDLE: begin
            count <= '0;
            waited <= 13'h0000;
            if (action inside {sec_pkg::ACT_RUN, sec_pkg::ACT_REPEAT,
                               sec_pkg::ACT_MAN_EXP, sec_pkg::ACT_MAN_READ}) begin
              state <= sec_pkg::SEC_RUN;
              started <= 1'b1;
            end else if (action inside {sec_pkg::ACT_DELAY, sec_pkg::ACT_DELAY_REPEAT}) begin
              if (delay == 13'h0000) begin
                state <= sec_pkg::SEC_RUN;
                started <= 1'b1;
              end else begin
                state <= sec_pkg::SEC_WAIT;
              end
            end
          end
          sec_pkg::SEC_WAIT: begin
            if (action == sec_pkg::ACT_IDLE) begin
              state <= sec_pkg::SEC_IDLE;
            end else if (waited + 13'h0001 >= delay) begin
              state <= sec_pkg::SEC_RUN;
              started <= 1'b1;
              waited <= 13'h0000;
              count <= '0;
            end else begin
              waited <= waited + 13'h0001;
            end
          end
          sec_pkg::SEC_RUN: begin
            if (action == sec_pkg::ACT_IDLE) begin
              state <= sec_pkg::SEC_IDLE;
              count <= '0;
            end else if (count == limit) begin
              case (action)
                sec_pkg::ACT_REPEAT: begin
                  count <= '0;
                  started <= 1'b1;
                end
                sec_pkg::ACT_DELAY_REPEAT: begin
                  count <= '0;
                  if (skip || delay == 13'h0000) begin
                    started <= 1'b1;
                  end else begin
                    state <= sec_pkg::SEC_WAIT;
                  end
                end
                // Manual modes hold at the limit until software moves on
                sec_pkg::ACT_MAN_EXP, sec_pkg::ACT_MAN_READ: count <= limit;
                default: state <= sec_pkg::SEC_DONE;
              endcase
            end else begin
              count <= count + W'(1);
            end
          end
          sec_pkg::SEC_DONE: begin
            if (action == sec_pkg::ACT_IDLE) begin
              state <= sec_pkg::SEC_IDLE;
              count <= '0;
            end
          end
        endcase
      end
    end
  end
endmodule

module sec_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic field_sync_in,
  input wire logic line_sync_in,
  input wire logic vertical_transfer_gate_in,
  input wire logic mode_count_active,
  output logic field_sync_out,
  output logic line_sync_out,
  output logic transfer_gate_out,
  output logic substrate_clock,
  output logic [7:0] general_output
);
  logic [27:0] shadow [sec_pkg::NUM_REGS];
  logic [27:0] act_ctrl, act_lim, act_dly, act_link;
  logic [27:13] act_mask;
  logic [12:0] act_gblank;
  logic [27:0] act_pulses, act_level, act_edges, act_fine;
  logic aw_hold, w_hold, aw_ok;
  logic [3:0] aw_slot;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_word, next_rdata;
  logic next_rok;
  logic commit;
  logic fs_level, fs_tick, ls_level, ls_tick, vtg_level, vtg_tick;
  logic field_step, sub_apply;
  logic p_active, p_started, s_active, s_started;
  logic [12:0] p_count;
  logic [11:0] s_count;
  logic [12:0] gate_left, sub_left;
  logic first_field;
  logic gate_masked, sub_masked, busy;
  logic [13:0] pix;
  logic [12:0] lines_after, pulses_done;
  logic train_wait, train_run, gate_line;

  assign commit = aw_hold && w_hold && !bvalid;

  sec_pin_sync u_fs (.clk(aclk), .rst_n(aresetn), .pin(field_sync_in),
                     .level(fs_level), .rise(fs_tick));
  sec_pin_sync u_ls (.clk(aclk), .rst_n(aresetn), .pin(line_sync_in),
                     .level(ls_level), .rise(ls_tick));
  sec_pin_sync u_vtg (.clk(aclk), .rst_n(aresetn), .pin(vertical_transfer_gate_in),
                      .level(vtg_level), .rise(vtg_tick));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_hold <= 1'b0;
      aw_ok <= 1'b0;
      aw_slot <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_hold <= 1'b1;
        aw_slot <= 4'(awaddr[9:2] - sec_pkg::IDX_ACTION);
        aw_ok <= (awaddr[11:10] == 2'h0) && (awaddr[9:2] >= sec_pkg::IDX_ACTION) &&
                 (awaddr[9:2] <= sec_pkg::IDX_TEST);
      end else if (commit) begin
        aw_hold <= 1'b0;
      end else if (!aw_hold && !bvalid && !awready) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_hold <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (commit) begin
        w_hold <= 1'b0;
      end else if (!w_hold && !bvalid && !wready) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= sec_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid <= 1'b1;
      bresp <= aw_ok ? sec_pkg::RESP_OKAY : sec_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_comb begin
    next_word = {4'h0, shadow[aw_slot]};
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_word[8*b +: 8] = w_data[8*b +: 8];
      end
    end
  end

  // Software sees its own written values; hardware runs on the applied copies, save the apply bit read straight from the shadow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < sec_pkg::NUM_REGS; i++) begin
        shadow[i] <= sec_pkg::RST_ZERO;
      end
      shadow[4'(sec_pkg::IDX_MASKS - sec_pkg::IDX_ACTION)] <= sec_pkg::RST_MASKS;
    end else if (commit && aw_ok) begin
      unique case (aw_slot)
        4'(sec_pkg::IDX_ACTION - sec_pkg::IDX_ACTION): shadow[aw_slot] <= next_word[27:0] & sec_pkg::ACTION_MASK;
        4'(sec_pkg::IDX_LINKS - sec_pkg::IDX_ACTION): shadow[aw_slot] <= next_word[27:0] & sec_pkg::LINK_MASK;
        4'(sec_pkg::IDX_LEVEL - sec_pkg::IDX_ACTION): shadow[aw_slot] <= next_word[27:0] & sec_pkg::LEVEL_MASK;
        4'(sec_pkg::IDX_TEST - sec_pkg::IDX_ACTION): shadow[aw_slot] <= next_word[27:0] & sec_pkg::TEST_WORD_MASK;
        default: shadow[aw_slot] <= next_word[27:0];
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rok = 1'b1;
    if (araddr[11:10] == 2'h0 && araddr[9:2] >= sec_pkg::IDX_ACTION &&
        araddr[9:2] <= sec_pkg::IDX_TEST) begin
      next_rdata = {4'h0, shadow[4'(araddr[9:2] - sec_pkg::IDX_ACTION)]};
    end else if (araddr[11:10] == 2'h0 && araddr[9:2] == sec_pkg::IDX_STATUS) begin
      next_rdata = {4'h0, train_run, s_active, p_active, s_count, p_count};
    end else begin
      next_rok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= sec_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= next_rok ? sec_pkg::RESP_OKAY : sec_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid && !arready) begin
        arready <= 1'b1;
      end
    end
  end

  assign sub_apply = shadow[4'(sec_pkg::IDX_MASKS - sec_pkg::IDX_ACTION)][sec_pkg::APPLY_BIT]
                     ? fs_tick : vtg_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_ctrl <= sec_pkg::RST_ZERO;
      act_lim <= sec_pkg::RST_ZERO;
      act_dly <= sec_pkg::RST_ZERO;
      act_link <= sec_pkg::RST_ZERO;
      act_gblank <= 13'h0000;
    end else if (fs_tick) begin
      act_ctrl <= shadow[4'(sec_pkg::IDX_ACTION - sec_pkg::IDX_ACTION)];
      act_lim <= shadow[4'(sec_pkg::IDX_LIMITS - sec_pkg::IDX_ACTION)];
      act_dly <= shadow[4'(sec_pkg::IDX_DELAYS - sec_pkg::IDX_ACTION)];
      act_link <= shadow[4'(sec_pkg::IDX_LINKS - sec_pkg::IDX_ACTION)];
      act_gblank <= shadow[4'(sec_pkg::IDX_MASKS - sec_pkg::IDX_ACTION)][12:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_mask[27:13] <= sec_pkg::RST_MASKS[27:13];
      act_pulses <= sec_pkg::RST_ZERO;
      act_level <= sec_pkg::RST_ZERO;
      act_edges <= sec_pkg::RST_ZERO;
      act_fine <= sec_pkg::RST_ZERO;
    end else if (sub_apply) begin
      act_mask[27:13] <= shadow[4'(sec_pkg::IDX_MASKS - sec_pkg::IDX_ACTION)][27:13];
      act_pulses <= shadow[4'(sec_pkg::IDX_PULSES - sec_pkg::IDX_ACTION)];
      act_level <= shadow[4'(sec_pkg::IDX_LEVEL - sec_pkg::IDX_ACTION)];
      act_edges <= shadow[4'(sec_pkg::IDX_EDGES - sec_pkg::IDX_ACTION)];
      act_fine <= shadow[4'(sec_pkg::IDX_FINE - sec_pkg::IDX_ACTION)];
    end
  end

  // One cycle late so counters see the settings applied at this field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_step <= 1'b0;
    end else begin
      field_step <= fs_tick;
    end
  end

  sec_field_counter #(.W(13)) u_primary (
    .clk(aclk), .rst_n(aresetn), .field_step(field_step),
    .action(act_ctrl[sec_pkg::ACT_P_LSB +: 3]),
    .limit(act_lim[sec_pkg::PMAX_LSB +: 13]),
    .delay(act_dly[sec_pkg::PDLY_LSB +: 13]),
    .skip(act_dly[sec_pkg::PSKIP_BIT]),
    .active(p_active), .started(p_started), .count(p_count)
  );

  sec_field_counter #(.W(12)) u_secondary (
    .clk(aclk), .rst_n(aresetn), .field_step(field_step),
    .action(act_ctrl[sec_pkg::ACT_S_LSB +: 3]),
    .limit(act_lim[sec_pkg::SMAX_LSB +: 12]),
    .delay(act_dly[sec_pkg::SDLY_LSB +: 13]),
    .skip(act_dly[sec_pkg::SSKIP_BIT]),
    .active(s_active), .started(s_started), .count(s_count)
  );

  // Exposure starts when the primary counter starts a count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_left <= 13'h0000;
      sub_left <= 13'h0000;
      first_field <= 1'b0;
    end else if (p_started) begin
      gate_left <= act_gblank;
      sub_left <= act_mask[sec_pkg::SBLANK_LSB +: 13];
      first_field <= 1'b1;
    end else if (field_step) begin
      first_field <= 1'b0;
      if (gate_left != 13'h0000) begin
        gate_left <= gate_left - 13'h0001;
      end
      if (sub_left != 13'h0000) begin
        sub_left <= sub_left - 13'h0001;
      end
    end
  end

  assign gate_masked = (gate_left != 13'h0000);
  assign sub_masked = (sub_left != 13'h0000) &&
                      !(act_mask[sec_pkg::SKIP1_BIT] && first_field);

  always_ff @(posedge aclk) begin
    if (!aresetn || ls_tick) begin
      pix <= 14'h0000;
    end else if (pix != 14'h3FFF) begin
      pix <= pix + 14'h0001;
    end
  end

  // Pulse train, one substrate pulse per line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lines_after <= 13'h0000;
      pulses_done <= 13'h0000;
      train_wait <= 1'b0;
      train_run <= 1'b0;
      gate_line <= 1'b0;
    end else begin
      if (vtg_tick) begin
        gate_line <= 1'b1;
      end else if (ls_tick) begin
        gate_line <= 1'b0;
      end
      if (vtg_tick) begin
        lines_after <= 13'h0000;
        train_wait <= 1'b1;
        train_run <= 1'b0;
      end else if (fs_tick && !act_pulses[sec_pkg::INHIBIT_BIT]) begin
        train_wait <= 1'b0;
        train_run <= 1'b0;
      end else if (ls_tick && train_wait) begin
        if (lines_after == act_pulses[sec_pkg::OFS_LSB +: 13]) begin
          train_wait <= 1'b0;
          train_run <= (act_pulses[sec_pkg::PULSES_LSB +: 13] != 13'h0000);
          pulses_done <= 13'h0000;
        end else begin
          lines_after <= lines_after + 13'h0001;
        end
      end else if (ls_tick && train_run) begin
        if (pulses_done + 13'h0001 >= act_pulses[sec_pkg::PULSES_LSB +: 13]) begin
          train_run <= 1'b0;
        end
        pulses_done <= pulses_done + 13'h0001;
      end
    end
  end

  assign busy = p_active | (act_lim[sec_pkg::BLANK_LSB + sec_pkg::BLANK_SEC_BIT] & s_active);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_sync_out <= 1'b0;
      line_sync_out <= 1'b0;
      transfer_gate_out <= 1'b0;
      substrate_clock <= 1'b0;
    end else begin
      field_sync_out <= fs_level &
                        ~(act_lim[sec_pkg::BLANK_LSB + sec_pkg::BLANK_FS_BIT] & busy);
      line_sync_out <= ls_level &
                       ~(act_lim[sec_pkg::BLANK_LSB + sec_pkg::BLANK_LS_BIT] & busy);
      transfer_gate_out <= vtg_level & ~gate_masked &
                           ~act_pulses[sec_pkg::INHIBIT_BIT];
      substrate_clock <= act_level[sec_pkg::LEVEL_BIT] ^ (!sub_masked &&
        ((train_run && pix >= act_edges[sec_pkg::EDGE_A_LSB +: 14] &&
          pix < act_edges[sec_pkg::EDGE_B_LSB +: 14]) ||
         (gate_line && pix >= act_fine[sec_pkg::EDGE_A_LSB +: 14] &&
          pix < act_fine[sec_pkg::EDGE_B_LSB +: 14])));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_output <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        unique case (act_link[sec_pkg::LINK_W*i +: 3])
          sec_pkg::LINK_HAND: general_output[i] <= act_ctrl[sec_pkg::FIRE_LSB + i];
          sec_pkg::LINK_MODE: general_output[i] <= mode_count_active;
          sec_pkg::LINK_PRIMARY: general_output[i] <= p_active;
          sec_pkg::LINK_SECONDARY: general_output[i] <= s_active;
          sec_pkg::LINK_ON: general_output[i] <= 1'b1;
          default: general_output[i] <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ===== inc/sec_pkg.sv
// Summary of operation
// - Two 3-bit action selectors, primary and secondary
// - Code 0 idles, count cleared each field
// - Code 1 runs once, code 2 repeats
// - Code 3 delays start, code 4 delays and repeats
// - Codes 5/6 manual exposure/read, 7 forces idle
// - Hand fire bits drive outputs with link code 1
// - Primary limit 13 bits, secondary limit 12 bits
// - Blank select hides syncs while counters run
// - Primary start delay in fields, per repetition
// - Secondary start delay in fields, per repetition
// - Skip bit applies delay before first count only
// - Eight packed 3-bit output link selectors
// - Link codes: idle, mode, primary, secondary, on
// - Gate blanked for programmed exposure fields
// - Substrate blanked for exposure plus readout fields
// - Apply point picks gate line or field sync
// - Skip-first drops substrate blank in first field
// - Substrate pulses start offset lines after gate
// - Pulse count per field, below field length
// - Gate inhibit suppresses gate, pulses run to count
// - Start level, two edges, two fine edges
package sec_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_REGS = 10;
  localparam logic [7:0] IDX_ACTION = 8'h70;
  localparam logic [7:0] IDX_LIMITS = 8'h71;
  localparam logic [7:0] IDX_DELAYS = 8'h72;
  localparam logic [7:0] IDX_LINKS = 8'h73;
  localparam logic [7:0] IDX_MASKS = 8'h74;
  localparam logic [7:0] IDX_PULSES = 8'h75;
  localparam logic [7:0] IDX_LEVEL = 8'h76;
  localparam logic [7:0] IDX_EDGES = 8'h77;
  localparam logic [7:0] IDX_FINE = 8'h78;
  localparam logic [7:0] IDX_TEST = 8'h79;
  localparam logic [7:0] IDX_STATUS = 8'h80;
  localparam logic [27:0] RST_ZERO = 28'h000_0000;
  localparam logic [27:0] RST_MASKS = 28'h400_0000;
  localparam logic [27:0] TEST_WORD_MASK = 28'h3FF_FFFF;
  localparam logic [27:0] LEVEL_MASK = 28'h000_0003;
  localparam logic [27:0] LINK_MASK = 28'h0FF_FFFF;
  localparam logic [27:0] ACTION_MASK = 28'h000_3FFF;
  localparam int ACT_P_LSB = 0;
  localparam int ACT_S_LSB = 3;
  localparam int FIRE_LSB = 6;
  localparam int PMAX_LSB = 0;
  localparam int SMAX_LSB = 13;
  localparam int BLANK_LSB = 25;
  localparam int PDLY_LSB = 0;
  localparam int PSKIP_BIT = 13;
  localparam int SDLY_LSB = 14;
  localparam int SSKIP_BIT = 27;
  localparam int LINK_W = 3;
  localparam int GBLANK_LSB = 0;
  localparam int SBLANK_LSB = 13;
  localparam int APPLY_BIT = 26;
  localparam int SKIP1_BIT = 27;
  localparam int OFS_LSB = 1;
  localparam int PULSES_LSB = 14;
  localparam int INHIBIT_BIT = 27;
  localparam int LEVEL_BIT = 0;
  localparam int EDGE_A_LSB = 0;
  localparam int EDGE_B_LSB = 14;
  localparam int BLANK_FS_BIT = 0;
  localparam int BLANK_LS_BIT = 1;
  localparam int BLANK_SEC_BIT = 2;
  localparam logic [2:0] ACT_IDLE = 3'h0;
  localparam logic [2:0] ACT_RUN = 3'h1;
  localparam logic [2:0] ACT_REPEAT = 3'h2;
  localparam logic [2:0] ACT_DELAY = 3'h3;
  localparam logic [2:0] ACT_DELAY_REPEAT = 3'h4;
  localparam logic [2:0] ACT_MAN_EXP = 3'h5;
  localparam logic [2:0] ACT_MAN_READ = 3'h6;
  localparam logic [2:0] ACT_FORCE_IDLE = 3'h7;
  localparam logic [2:0] LINK_IDLE = 3'h0;
  localparam logic [2:0] LINK_HAND = 3'h1;
  localparam logic [2:0] LINK_MODE = 3'h4;
  localparam logic [2:0] LINK_PRIMARY = 3'h5;
  localparam logic [2:0] LINK_SECONDARY = 3'h6;
  localparam logic [2:0] LINK_ON = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEC_IDLE, SEC_WAIT, SEC_RUN, SEC_DONE} sec_cnt_state_e;
endpackage

// ===== test/sec_core_monitor.sv
`timescale 1ns/1ps
module sec_core_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_reopen;
    !bvalid ##1 (awready && wready);
  endsequence
  chk_write_answer: assert property (s_wr_take |-> ##2 bvalid)
    else $error("write response missing");
  chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_write_turn: assert property (bvalid && bready |=> s_wr_reopen)
    else $error("write channel not reopened");
  chk_write_single: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  chk_data_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_read_turn: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");
  chk_read_top: assert property (rvalid |-> rdata[31:28] == 4'h0)
    else $error("read data above 28 bits");
endmodule
bind sec_core sec_core_monitor mon_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready);

// ===== test/sec_sensor_model.sv
`timescale 1ns/1ps
module sec_sensor_model (
  input wire logic clk,
  input wire logic field_req,
  input wire logic gate_req,
  output logic field_sync,
  output logic line_sync,
  output logic gate_line
);
  logic [5:0] pix = 6'h00;
  // Lines free-run at 48 cycles; field length stays far above any pulse count
  always @(posedge clk) begin
    pix <= (pix == 6'h2F) ? 6'h00 : pix + 6'h01;
    field_sync <= field_req;
    gate_line <= gate_req;
  end
  assign line_sync = pix < 6'h08;
endmodule

// ===== test/sec_core_tb.sv
`timescale 1ns/1ps
module sec_core_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, field_req, gate_req, mode_count_active;
  logic field_sync_in, line_sync_in, vertical_transfer_gate_in;
  logic field_sync_out, line_sync_out, transfer_gate_out, substrate_clock;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] general_output;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  int miscompares, samples_checked;
  sec_core dut_u (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .field_sync_in, .line_sync_in, .vertical_transfer_gate_in,
    .mode_count_active, .field_sync_out, .line_sync_out, .transfer_gate_out, .substrate_clock,
    .general_output);
  sec_sensor_model pm_u (.clk(aclk), .field_req, .gate_req, .field_sync(field_sync_in),
    .line_sync(line_sync_in), .gate_line(vertical_transfer_gate_in));
  task automatic end_of_test;
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang;
    miscompares++;
    end_of_test();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 100) hang();
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 100) hang();
    end while (!rvalid);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Pulses are wide so the input filter accepts them
  task automatic pulse(input logic gate);
    @(posedge aclk);
    if (gate) gate_req <= 1'b1;
    else field_req <= 1'b1;
    repeat (8) @(posedge aclk);
    gate_req <= 1'b0;
    field_req <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask
  task automatic fields(input int k);
    repeat (k) pulse(1'b0);
  endtask
  function automatic logic [27:0] keep(input int i);
    case (i)
      0: keep = sec_pkg::ACTION_MASK;
      3: keep = sec_pkg::LINK_MASK;
      6: keep = sec_pkg::LEVEL_MASK;
      default: keep = 28'hFFF_FFFF;
    endcase
  endfunction
  task automatic t_reset_values;
    for (int i = 0; i < 10; i++) begin
      rd(12'(4 * (8'h70 + i)));
      check("reset value", got, i == 4 ? {4'h0, sec_pkg::RST_MASKS} : 32'h0000_0000);
    end
    rd(12'h100);
    check("unmapped read", {got[29:0], resp}, 32'h0000_0002);
  endtask
  task automatic t_field_widths;
    logic [31:0] w;
    for (int i = 0; i < 9; i++) begin
      w = 32'hFFFF_FFFF;
      if (i == 5) w[0] = 1'b0;
      if (i == 6) w[1] = 1'b0;
      wr(12'(4 * (8'h70 + i)), w);
      rd(12'(4 * (8'h70 + i)));
      check("field width", got, {4'h0, keep(i) & w[27:0]});
      wr(12'(4 * (8'h70 + i)), i == 4 ? {4'h0, sec_pkg::RST_MASKS} : 32'h0000_0000);
    end
    wr(12'h200, 32'h0000_0001);
    check("status write", {30'h0, resp}, {30'h0, sec_pkg::RESP_SLVERR});
  endtask
  task automatic t_links;
    mode_count_active <= 1'b1;
    wr(12'h1CC, {8'h00, 3'h6, 3'h5, 3'h3, 3'h2, 3'h0, 3'h4, 3'h1, 3'h7});
    wr(12'h1C0, 32'h0000_0080);
    check("held in shadow", {24'h0, general_output}, 32'h0000_0000);
    fields(1);
    check("link codes", {24'h0, general_output}, 32'h0000_0007);
    mode_count_active <= 1'b0;
    repeat (3) @(posedge aclk);
    check("mode link", {24'h0, general_output}, 32'h0000_0003);
    wr(12'h1C0, 32'h0000_0000);
    fields(1);
    check("hand fire off", {24'h0, general_output}, 32'h0000_0001);
  endtask
  task automatic act(input logic [31:0] code, input int k, input logic [1:0] run);
    wr(12'h1C0, code);
    fields(k);
    rd(12'h200);
    check("running flags", {30'h0, got[26:25]}, {30'h0, run});
  endtask
  task automatic t_counters;
    wr(12'h1C4, 32'h0000_2002);
    act(32'h0000_0009, 3, 2'b01);
    check("primary link", {31'h0, general_output[6]}, 32'h0000_0001);
    act(32'h0000_0009, 5, 2'b00);
    act(32'h0000_0000, 1, 2'b00);
    check("idle counts", {7'h0, got[24:0]}, 32'h0000_0000);
    act(32'h0000_0012, 8, 2'b11);
    act(32'h0000_003F, 1, 2'b00);
    wr(12'h1C4, 32'h0000_0008);
    wr(12'h1C8, 32'h0000_0003);
    act(32'h0000_0003, 2, 2'b00);
    act(32'h0000_0003, 4, 2'b01);
    act(32'h0000_0007, 1, 2'b00);
    act(32'h0000_0004, 6, 2'b01);
    act(32'h0000_0004, 7, 2'b00);
    act(32'h0000_0007, 1, 2'b00);
    act(32'h0000_0035, 3, 2'b11);
    act(32'h0000_003F, 1, 2'b00);
  endtask
  task automatic t_substrate;
    wr(12'h1D8, 32'h0000_0001);
    fields(1);
    check("start level", {31'h0, substrate_clock}, 32'h0000_0001);
    wr(12'h1D0, 32'h0000_0000);
    wr(12'h1D8, 32'h0000_0000);
    fields(1);
    check("level before gate", {31'h0, substrate_clock}, 32'h0000_0001);
    pulse(1'b1);
    check("level at gate line", {31'h0, substrate_clock}, 32'h0000_0000);
  endtask
  task automatic look(input logic on);
    for (int n = 0; n < 50 && line_sync_in; n++) @(posedge aclk);
    for (int n = 0; n < 50 && !line_sync_in; n++) @(posedge aclk);
    if (!line_sync_in) hang();
    repeat (6) @(posedge aclk);
    check("line out", {31'h0, line_sync_out}, {31'h0, on});
    {gate_req, field_req} <= 2'h3;
    repeat (7) @(posedge aclk);
    check("field out", {31'h0, field_sync_out}, {31'h0, on});
    check("gate out", {31'h0, transfer_gate_out}, {31'h0, on});
    {gate_req, field_req} <= 2'h0;
    repeat (30) @(posedge aclk);
  endtask
  task automatic t_syncs;
    look(1'b1);
    wr(12'h1C4, 32'h0600_0000);
    wr(12'h1C0, 32'h0000_0002);
    wr(12'h1D4, 32'h0800_0000);
    fields(1);
    pulse(1'b1);
    look(1'b0);
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {field_req, gate_req, mode_count_active} = 3'h0;
    {awaddr, araddr, awprot, arprot} = 30'h0000_0000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_field_widths();
    t_links();
    t_counters();
    t_substrate();
    t_syncs();
    end_of_test();
  end
endmodule
